// file: rtl/scsr_regs.svh
// register offsets, field positions and codes of the serial status readout
`ifndef SCSR_REGS_SVH
`define SCSR_REGS_SVH
// ****************************************
// word indices, byte address = index * 4
// ****************************************
`define SCSR_IDX_MODE 5'h00
`define SCSR_IDX_CLK_CMD 5'h01
`define SCSR_IDX_LEN_CTRL 5'h02
`define SCSR_IDX_LEN_SET 5'h03
`define SCSR_IDX_LOOP_CTRL 5'h04
`define SCSR_IDX_INT_EN 5'h05
`define SCSR_IDX_RX_DIV 5'h06
`define SCSR_IDX_TX_DIV 5'h07
`define SCSR_IDX_ZERO_CLR 5'h08
`define SCSR_IDX_RATE_RES 5'h10
`define SCSR_IDX_PEND_A 5'h11
`define SCSR_IDX_LEN_LO 5'h12
`define SCSR_IDX_LEN_HI 5'h13
`define SCSR_IDX_CLK_LOOP 5'h14
`define SCSR_IDX_INT_EN_RB 5'h15
`define SCSR_IDX_RX_DIV_LO 5'h16
`define SCSR_IDX_RX_DIV_HI 5'h17
`define SCSR_IDX_TX_DIV_LO 5'h18
`define SCSR_IDX_TX_DIV_HI 5'h19
`define SCSR_IDX_PEND_B 5'h1a
// ****************************************
// fields
// ****************************************
`define SCSR_MODE_BOP 0
`define SCSR_MODE_COP 1
`define SCSR_MODE_FM 2
`define SCSR_MODE_DPLL 3
`define SCSR_MODE_TXEN 4
`define SCSR_MODE_LEN_LSB 5
`define SCSR_CC_TX_EN 0
`define SCSR_CC_RX_EN 1
`define SCSR_CC_CMD_LSB 5
`define SCSR_LC_CLEAR 8
`define SCSR_LOOP_A 4
`define SCSR_LOOP_B 1
`define SCSR_IE_ES 0
`define SCSR_ZC_TX 1
`define SCSR_ZC_RX 0
`define SCSR_CMD_SEARCH 3'h1
`define SCSR_CMD_RST_MISS 3'h2
`define SCSR_LEN_8 2'h3
`define SCSR_LEN_7 2'h2
`define SCSR_LEN_6 2'h1
`define SCSR_NORES_8 3'h3
`define SCSR_NORES_7 3'h3
`define SCSR_NORES_6 3'h0
`define SCSR_NORES_5 3'h4
`define SCSR_MISS_BITS 2'h2
`define SCSR_ZERO8 8'h00
`define SCSR_ZERO16 16'h0000
`define SCSR_ZERO32 32'h0000_0000
`endif

// file: rtl/scsr_pkg.sv
// types of the serial status readout
package scsr_pkg;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] mode;
        logic [7:0] clk_cmd;
        logic [15:0] len_set;
        logic [7:0] loop_ctrl;
        logic [7:0] int_en;
        logic [15:0] rx_div;
        logic [15:0] tx_div;
        logic [15:0] rx_cnt;
        logic [15:0] tx_cnt;
        logic tx_zero;
        logic rx_zero;
        logic es_req;
        logic [2:0] residue;
        logic [15:0] len_cnt;
        logic abort;
        logic [1:0] bits_quiet;
        logic miss_run;
        logic one_miss;
        logic two_miss;
        logic on_loop;
        logic tx_sync;
        logic rxd_s1;
        logic rxd_s2;
        logic rxd_dly;
        logic txd;
        logic [7:0] pending;
    } scsr_state_t;
endpackage

// file: rtl/scsr_status.sv
// status readout of a two-channel serial controller behind a wishbone slave
//
// What this block does
// - tx generator zero sets flag when enabled
// - flag latched rising, raises status request
// - rx generator zero flag, same behaviour
// - bit-oriented residue code reports valid bits
// - residue spans previous and second previous character
// - eight bits, code 000: two bits valid
// - boundary codes flagged as no residue
// - pending bit: serviced or lower waiting
// - pending map readable only via channel A
// - pending bits in fixed channel order
// - length counter low byte readable
// - length counter high byte readable
// - underrun with length mismatch sends abort
// - length counter cleared by reset, clear bit
// - no transition in two bits sets flag
// - missing flag cleared by two commands only
// - two missed windows set second flag
// - sending-on-loop while in loop transmitting
// - character mode sync sets transmit-sync flag
// - go-ahead inserts one-bit delay, sets on-loop
// - on-loop holds while loop, else zero
// - interrupt enables read back
// - rx divisor read back in two bytes
// - tx divisor read back in two bytes
// - zero flags qualify general zero flag
// - residue taken only at end of frame
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "scsr_regs.svh"
module scsr_status
    import scsr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [6:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // receiver and transmitter events
    input wire logic frame_end_in,
    input wire logic [2:0] residue_in,
    input wire logic tx_byte_sent_in,
    input wire logic tx_underrun_in,
    input wire logic tx_active_in,
    input wire logic rx_edge_in,
    input wire logic bit_tick_in,
    input wire logic go_ahead_in,
    input wire logic sync_done_in,
    // interrupt controller view
    input wire logic [7:0] int_req_in,
    input wire logic [7:0] int_service_in,
    // serial line
    input wire logic rxd_in,
    input wire logic tx_data_in,
    output logic txd_out,
    // status outputs
    output logic es_request_out,
    output logic rate_zero_out,
    output logic abort_out,
    output logic no_residue_out
);
    // ****************************************
    // state
    // ****************************************
    scsr_state_t st_ff;
    scsr_state_t nxt_st;
    logic no_res_ff;
    logic nxt_no_res;
    logic rate_zero_ff;
    logic [7:0] below_mask;

    // ****************************************
    // lower-priority mask under the highest serviced cause
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            // bit 7 ranks highest; a bit is below if any higher bit is serviced
            if (gi == 7) begin : g_top
                assign below_mask[gi] = 1'b0;
            end else begin : g_low
                assign below_mask[gi] = |int_service_in[7:gi+1];
            end
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic acc;
        logic wr;
        logic [4:0] idx;
        logic bit_oriented_mode;
        logic character_oriented_mode;
        logic loop_sel;
        logic tx_hit;
        logic rx_hit;
        logic miss_evt;
        acc = wb_cyc_in && wb_stb_in && !st_ff.ack;
        wr = acc && wb_we_in && wb_sel_in[0];
        idx = wb_adr_in[6:2];
        nxt_st = st_ff;
        nxt_no_res = no_res_ff;
        bit_oriented_mode = st_ff.mode[`SCSR_MODE_BOP];
        character_oriented_mode = st_ff.mode[`SCSR_MODE_COP];
        loop_sel = st_ff.loop_ctrl[`SCSR_LOOP_A] && st_ff.loop_ctrl[`SCSR_LOOP_B];
        tx_hit = st_ff.clk_cmd[`SCSR_CC_TX_EN] && (st_ff.tx_cnt == `SCSR_ZERO16);
        rx_hit = st_ff.clk_cmd[`SCSR_CC_RX_EN] && (st_ff.rx_cnt == `SCSR_ZERO16);
        miss_evt = 1'b0;
        nxt_st.ack = acc;
        nxt_st.abort = 1'b0;

        // rate generators count down and reload
        if (st_ff.clk_cmd[`SCSR_CC_TX_EN]) begin
            if (st_ff.tx_cnt == `SCSR_ZERO16) begin
                nxt_st.tx_cnt = st_ff.tx_div;
                nxt_st.tx_zero = 1'b1;
            end else begin
                nxt_st.tx_cnt = st_ff.tx_cnt - 16'h0001;
            end
        end
        if (st_ff.clk_cmd[`SCSR_CC_RX_EN]) begin
            if (st_ff.rx_cnt == `SCSR_ZERO16) begin
                nxt_st.rx_cnt = st_ff.rx_div;
                nxt_st.rx_zero = 1'b1;
            end else begin
                nxt_st.rx_cnt = st_ff.rx_cnt - 16'h0001;
            end
        end
        // only a new zero-to-one edge raises the status request
        if ((nxt_st.tx_zero && !st_ff.tx_zero) || (nxt_st.rx_zero && !st_ff.rx_zero)) begin
            nxt_st.es_req = st_ff.int_en[`SCSR_IE_ES];
        end

        // residue taken at end of frame only
        if (frame_end_in && bit_oriented_mode) begin
            nxt_st.residue = residue_in;
            case (st_ff.mode[`SCSR_MODE_LEN_LSB +: 2])
                `SCSR_LEN_8: nxt_no_res = (residue_in == `SCSR_NORES_8);
                `SCSR_LEN_7: nxt_no_res = (residue_in == `SCSR_NORES_7);
                `SCSR_LEN_6: nxt_no_res = (residue_in == `SCSR_NORES_6);
                default: nxt_no_res = (residue_in == `SCSR_NORES_5);
            endcase
        end

        // transmit length counter and abort on mismatch
        if (bit_oriented_mode && tx_byte_sent_in) begin
            nxt_st.len_cnt = st_ff.len_cnt + 16'h0001;
        end
        if (bit_oriented_mode && tx_underrun_in && (st_ff.len_set != st_ff.len_cnt)) begin
            nxt_st.abort = 1'b1;
        end

        // missing clock watch in fm with the dpll running
        if (st_ff.mode[`SCSR_MODE_FM] && st_ff.mode[`SCSR_MODE_DPLL]) begin
            if (rx_edge_in) begin
                nxt_st.bits_quiet = 2'h0;
                nxt_st.miss_run = 1'b0;
            end else if (bit_tick_in) begin
                if (st_ff.bits_quiet + 2'h1 == `SCSR_MISS_BITS) begin
                    nxt_st.bits_quiet = 2'h0;
                    nxt_st.one_miss = 1'b1;
                    miss_evt = 1'b1;
                    nxt_st.miss_run = 1'b1;
                    if (st_ff.miss_run) begin
                        nxt_st.two_miss = 1'b1;
                    end
                end else begin
                    nxt_st.bits_quiet = st_ff.bits_quiet + 2'h1;
                end
            end
        end

        // loop handling
        if (!(bit_oriented_mode && loop_sel)) begin
            nxt_st.on_loop = 1'b0;
        end else if (go_ahead_in) begin
            nxt_st.on_loop = 1'b1;
        end
        if (character_oriented_mode && sync_done_in && !st_ff.loop_ctrl[`SCSR_LOOP_A]
            && !st_ff.loop_ctrl[`SCSR_LOOP_B] && st_ff.mode[`SCSR_MODE_TXEN]) begin
            nxt_st.tx_sync = 1'b1;
        end else if (!character_oriented_mode || !st_ff.mode[`SCSR_MODE_TXEN]) begin
            nxt_st.tx_sync = 1'b0;
        end
        nxt_st.rxd_s1 = rxd_in;
        nxt_st.rxd_s2 = st_ff.rxd_s1;
        nxt_st.rxd_dly = st_ff.rxd_s2;
        // one bit of delay from receive to transmit while on loop
        nxt_st.txd = st_ff.on_loop ? st_ff.rxd_dly : tx_data_in;

        // pending map
        nxt_st.pending = int_service_in | (int_req_in & below_mask);

        // register writes, set wins over clear
        if (wr) begin
            if (idx == `SCSR_IDX_MODE) begin
                nxt_st.mode = wb_dat_in[7:0];
            end else if (idx == `SCSR_IDX_CLK_CMD) begin
                nxt_st.clk_cmd = wb_dat_in[7:0];
                if (wb_dat_in[`SCSR_CC_CMD_LSB +: 3] == `SCSR_CMD_RST_MISS
                    || wb_dat_in[`SCSR_CC_CMD_LSB +: 3] == `SCSR_CMD_SEARCH) begin
                    // a window missed in this very cycle survives the command
                    nxt_st.one_miss = miss_evt;
                    nxt_st.two_miss = miss_evt && st_ff.miss_run;
                    nxt_st.miss_run = miss_evt;
                    nxt_st.bits_quiet = 2'h0;
                end
            end else if (idx == `SCSR_IDX_LEN_CTRL) begin
                if (wb_sel_in[1] && wb_dat_in[`SCSR_LC_CLEAR]) begin
                    nxt_st.len_cnt = `SCSR_ZERO16;
                end
            end else if (idx == `SCSR_IDX_LEN_SET) begin
                nxt_st.len_set[7:0] = wb_dat_in[7:0];
                if (wb_sel_in[1]) begin
                    nxt_st.len_set[15:8] = wb_dat_in[15:8];
                end
            end else if (idx == `SCSR_IDX_LOOP_CTRL) begin
                nxt_st.loop_ctrl = wb_dat_in[7:0];
            end else if (idx == `SCSR_IDX_INT_EN) begin
                nxt_st.int_en = wb_dat_in[7:0];
            end else if (idx == `SCSR_IDX_RX_DIV) begin
                nxt_st.rx_div[7:0] = wb_dat_in[7:0];
                if (wb_sel_in[1]) begin
                    nxt_st.rx_div[15:8] = wb_dat_in[15:8];
                end
            end else if (idx == `SCSR_IDX_TX_DIV) begin
                nxt_st.tx_div[7:0] = wb_dat_in[7:0];
                if (wb_sel_in[1]) begin
                    nxt_st.tx_div[15:8] = wb_dat_in[15:8];
                end
            end else if (idx == `SCSR_IDX_ZERO_CLR) begin
                // a countdown hit in the same cycle beats the clear
                if (wb_dat_in[`SCSR_ZC_TX] && !tx_hit) begin
                    nxt_st.tx_zero = 1'b0;
                end
                if (wb_dat_in[`SCSR_ZC_RX] && !rx_hit) begin
                    nxt_st.rx_zero = 1'b0;
                end
                nxt_st.es_req = (nxt_st.es_req && !(st_ff.tx_zero || st_ff.rx_zero))
                    || (st_ff.int_en[`SCSR_IE_ES] && ((nxt_st.tx_zero && !st_ff.tx_zero)
                    || (nxt_st.rx_zero && !st_ff.rx_zero)));
            end
        end

        // register reads, no side effects on any flag
        nxt_st.rdata = `SCSR_ZERO32;
        if (acc && !wb_we_in) begin
            if (idx == `SCSR_IDX_MODE) begin
                nxt_st.rdata[7:0] = st_ff.mode;
            end else if (idx == `SCSR_IDX_CLK_CMD) begin
                nxt_st.rdata[7:0] = st_ff.clk_cmd;
            end else if (idx == `SCSR_IDX_LEN_SET) begin
                nxt_st.rdata[15:0] = st_ff.len_set;
            end else if (idx == `SCSR_IDX_LOOP_CTRL) begin
                nxt_st.rdata[7:0] = st_ff.loop_ctrl;
            end else if (idx == `SCSR_IDX_INT_EN || idx == `SCSR_IDX_INT_EN_RB) begin
                nxt_st.rdata[7:0] = st_ff.int_en;
            end else if (idx == `SCSR_IDX_RX_DIV) begin
                nxt_st.rdata[15:0] = st_ff.rx_div;
            end else if (idx == `SCSR_IDX_TX_DIV) begin
                nxt_st.rdata[15:0] = st_ff.tx_div;
            end else if (idx == `SCSR_IDX_RATE_RES) begin
                // zero flags, then residue
                nxt_st.rdata[7:0] = {3'h0, st_ff.tx_zero, st_ff.rx_zero, st_ff.residue};
            end else if (idx == `SCSR_IDX_PEND_A) begin
                nxt_st.rdata[7:0] = st_ff.pending;
            end else if (idx == `SCSR_IDX_LEN_LO) begin
                nxt_st.rdata[7:0] = st_ff.len_cnt[7:0];
            end else if (idx == `SCSR_IDX_LEN_HI) begin
                nxt_st.rdata[7:0] = st_ff.len_cnt[15:8];
            end else if (idx == `SCSR_IDX_CLK_LOOP) begin
                nxt_st.rdata[7:0] = {st_ff.one_miss, st_ff.two_miss, 1'b0,
                    st_ff.on_loop && tx_active_in, 2'h0,
                    st_ff.on_loop || st_ff.tx_sync, 1'b0};
            end else if (idx == `SCSR_IDX_RX_DIV_LO) begin
                nxt_st.rdata[7:0] = st_ff.rx_div[7:0];
            end else if (idx == `SCSR_IDX_RX_DIV_HI) begin
                nxt_st.rdata[7:0] = st_ff.rx_div[15:8];
            end else if (idx == `SCSR_IDX_TX_DIV_LO) begin
                nxt_st.rdata[7:0] = st_ff.tx_div[7:0];
            end else if (idx == `SCSR_IDX_TX_DIV_HI) begin
                nxt_st.rdata[7:0] = st_ff.tx_div[15:8];
            end else begin
                // channel B pending alias and unmapped read as zero
                nxt_st.rdata = `SCSR_ZERO32;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= '0;
            no_res_ff <= 1'b0;
            rate_zero_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            no_res_ff <= nxt_no_res;
            rate_zero_ff <= nxt_st.tx_zero || nxt_st.rx_zero;
        end
    end

    assign wb_ack_out = st_ff.ack;
    assign wb_dat_out = st_ff.rdata;
    assign txd_out = st_ff.txd;
    assign es_request_out = st_ff.es_req;
    assign rate_zero_out = rate_zero_ff;
    assign abort_out = st_ff.abort;
    assign no_residue_out = no_res_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_TX_ZERO: assert property (st_ff.clk_cmd[0] && st_ff.tx_cnt == 16'h0000 |=> st_ff.tx_zero)
        else $error("tx zero flag not set");
    AST_RX_ZERO: assert property (st_ff.clk_cmd[1] && st_ff.rx_cnt == 16'h0000 |=> st_ff.rx_zero)
        else $error("rx zero flag not set");
    AST_ES_RISE: assert property ($rose(st_ff.es_req) |-> $rose(st_ff.tx_zero) || $rose(st_ff.rx_zero))
        else $error("status request without a zero edge");
    AST_ABORT: assert property (st_ff.mode[0] && tx_underrun_in && st_ff.len_set != st_ff.len_cnt |=> abort_out)
        else $error("abort missing on length mismatch");
    AST_LEN_CLR: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in == 4'hf
        && wb_adr_in[6:2] == 5'h02 && wb_dat_in[8] |=> st_ff.len_cnt == 16'h0000)
        else $error("length counter not cleared");
    AST_MISS_HOLD: assert property (st_ff.one_miss && !(wb_cyc_in && wb_stb_in && wb_we_in) |=> st_ff.one_miss)
        else $error("missing flag dropped without command");
    AST_TWO_MISS: assert property ($rose(st_ff.two_miss) |-> st_ff.one_miss)
        else $error("two missing without one missing");
    AST_LOOP_OFF: assert property (!st_ff.mode[0] |=> !st_ff.on_loop)
        else $error("on-loop set outside bit mode");
    AST_PEND: assert property (1'b1 |=> (st_ff.pending & $past(int_service_in)) == $past(int_service_in)
        && (st_ff.pending & ~($past(int_service_in) | $past(int_req_in))) == 8'h00)
        else $error("pending map wrong");
    AST_PEND_IDLE: assert property (int_service_in == 8'h00 |=> st_ff.pending == 8'h00)
        else $error("pending without a serviced cause");
    AST_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
        else $error("bus answer not one cycle");
endmodule

// file: tb/scsr_remote_station.sv
// remote station model driving the receive line with bit-paced transitions
`timescale 1ns/1ps
module scsr_remote_station (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // control: hold the line still when high
    input wire logic quiet_in,
    // serial line and timing
    output logic rxd_out,
    output logic rx_edge_out,
    output logic bit_tick_out
);
    logic [1:0] phase_ff;
    // ****
    // one bit every four clocks, transition at mid bit unless quiet
    // ****
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_ff <= 2'h0;
            rxd_out <= 1'b1;
            rx_edge_out <= 1'b0;
            bit_tick_out <= 1'b0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            bit_tick_out <= (phase_ff == 2'h3);
            rx_edge_out <= (phase_ff == 2'h1) && !quiet_in;
            if ((phase_ff == 2'h1) && !quiet_in) begin
                rxd_out <= ~rxd_out;
            end
        end
    end
endmodule

// file: tb/scsr_status_tb.sv
// self-checking bench of the serial status readout
`timescale 1ns/1ps
`include "scsr_regs.svh"
module scsr_status_tb;
    logic clk_in, rst_n_in, cyc, stb, we, ack, quiet, tx_act, tx_bit, rxd, edge_p, tick;
    logic es_req, rzero, abort_p, nores, txd;
    logic [6:0] adr;
    logic [3:0] sel, rxd_h;
    logic tx_prev;
    logic [31:0] dat, rdat, q, v;
    logic [4:0] ev;
    logic [2:0] res;
    logic [7:0] req, svc;
    int failures, checks_done, abort_cnt, cycles, i, n, seed;
    scsr_status dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .frame_end_in(ev[0]), .residue_in(res), .tx_byte_sent_in(ev[1]),
        .tx_underrun_in(ev[2]), .tx_active_in(tx_act), .rx_edge_in(edge_p),
        .bit_tick_in(tick), .go_ahead_in(ev[3]), .sync_done_in(ev[4]), .int_req_in(req),
        .int_service_in(svc), .rxd_in(rxd), .tx_data_in(tx_bit), .txd_out(txd),
        .es_request_out(es_req), .rate_zero_out(rzero), .abort_out(abort_p),
        .no_residue_out(nores));
    scsr_remote_station remote (.clk_in(clk_in), .rst_n_in(rst_n_in), .quiet_in(quiet),
        .rxd_out(rxd), .rx_edge_out(edge_p), .bit_tick_out(tick));
    // ****
    // clock, timeout and helpers
    // ****
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        tx_bit <= 1'($random(seed));
        tx_prev <= tx_bit;
        rxd_h <= {rxd_h[2:0], rxd};
        if (abort_p === 1'b1) begin
            abort_cnt++;
        end
        if (cycles == 6000) begin
            failures++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [4:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= {idx, 2'h0};
        dat <= d;
        do begin
            @(posedge clk_in);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        if (k >= 50) begin
            failures++;
        end
    endtask
    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        wb(1'b1, idx, d);
    endtask
    task automatic rdc(input string nm, input logic [4:0] idx, input logic [31:0] m, e);
        wb(1'b0, idx, 32'h0000_0000);
        chk(nm, q & m, e);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_in);
        ev <= 5'h01 << k;
        @(posedge clk_in);
        ev <= 5'h00;
    endtask
    function automatic logic [31:0] pend_exp(input logic [7:0] r, input logic [7:0] s);
        logic [31:0] p;
        p = 32'h0000_0000;
        for (int b = 0; b < 8; b++) begin
            p[b] = s[b] | (r[b] & |(s >> (b + 1)));
        end
        return p;
    endfunction
    function automatic logic [31:0] nores_exp(input logic [1:0] len, input logic [2:0] c);
        logic [2:0] nr;
        nr = (len == 2'h1) ? 3'h0 : ((len == 2'h0) ? 3'h4 : 3'h3);
        return {31'h0, c == nr};
    endfunction
    // ****
    // main sequence
    // ****
    initial begin
        seed = 32'h5034;
        {cyc, stb, we, quiet, tx_act} = 5'h00;
        {adr, sel, dat, ev, res, req, svc} = '0;
        rst_n_in = 1'b0;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rdc("len_rst", `SCSR_IDX_LEN_HI, 32'hff, 32'h0);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(`SCSR_IDX_INT_EN, v);
            wr(`SCSR_IDX_RX_DIV, v);
            wr(`SCSR_IDX_TX_DIV, v >> 16);
            wr(`SCSR_IDX_RX_DIV_LO, ~v);
            rdc("int_en", `SCSR_IDX_INT_EN_RB, 32'hff, 32'(v[7:0]));
            rdc("rx_lo", `SCSR_IDX_RX_DIV_LO, 32'hff, 32'(v[7:0]));
            rdc("rx_hi", `SCSR_IDX_RX_DIV_HI, 32'hff, 32'(v[15:8]));
            rdc("tx_lo", `SCSR_IDX_TX_DIV_LO, 32'hff, 32'(v[23:16]));
            rdc("tx_hi", `SCSR_IDX_TX_DIV_HI, 32'hff, 32'(v[31:24]));
        end
        rdc("unmapped", 5'h1f, 32'hffff_ffff, 32'h0);
        wr(`SCSR_IDX_INT_EN, 32'h01);
        wr(`SCSR_IDX_RX_DIV, 32'h03);
        wr(`SCSR_IDX_TX_DIV, 32'h03);
        for (i = 1; i < 3; i++) begin
            wr(`SCSR_IDX_CLK_CMD, i);
            repeat (20) @(posedge clk_in);
            rdc("zero", `SCSR_IDX_RATE_RES, 32'h18, (i == 1) ? 32'h10 : 32'h08);
            chk("rate_zero", 32'(rzero), 32'h1);
            chk("es_req", 32'(es_req), 32'h1);
            wr(`SCSR_IDX_CLK_CMD, 32'h0);
            wr(`SCSR_IDX_ZERO_CLR, 32'h3);
            rdc("zero_clr", `SCSR_IDX_RATE_RES, 32'h18, 32'h0);
        end
        for (i = 0; i < 32; i++) begin
            wr(`SCSR_IDX_MODE, {25'h0, i[4:3], 5'h01});
            res <= i[2:0];
            pulse(0);
            repeat (2) @(posedge clk_in);
            chk("no_residue", 32'(nores), nores_exp(i[4:3], i[2:0]));
            rdc("residue", `SCSR_IDX_RATE_RES, 32'h07, 32'(i[2:0]));
        end
        res <= 3'h2;
        rdc("residue_hold", `SCSR_IDX_RATE_RES, 32'h07, 32'h7);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            req <= v[7:0];
            svc <= (i == 0) ? 8'h80 : v[15:8];
            repeat (3) @(posedge clk_in);
            rdc("pend", `SCSR_IDX_PEND_A, 32'hff, pend_exp(v[7:0], svc));
            rdc("pend_b", `SCSR_IDX_PEND_B, 32'hff, 32'h0);
        end
        wr(`SCSR_IDX_MODE, 32'h01);
        n = 256 + ($random(seed) & 32'h1f);
        repeat (n) pulse(1);
        rdc("len_lo", `SCSR_IDX_LEN_LO, 32'hff, 32'(n[7:0]));
        rdc("len_lo", `SCSR_IDX_LEN_LO, 32'hff, 32'(n[7:0]));
        rdc("len_hi", `SCSR_IDX_LEN_HI, 32'hff, 32'(n[15:8]));
        for (i = 0; i < 2; i++) begin
            wr(`SCSR_IDX_LEN_SET, n + 1 - i);
            pulse(2);
            repeat (3) @(posedge clk_in);
            chk("abort", abort_cnt, 32'h1);
        end
        wr(`SCSR_IDX_LEN_CTRL, 32'h100);
        rdc("len_clr", `SCSR_IDX_LEN_LO, 32'hff, 32'h0);
        rdc("len_clr", `SCSR_IDX_LEN_HI, 32'hff, 32'h0);
        wr(`SCSR_IDX_MODE, 32'h0c);
        for (i = 0; i < 2; i++) begin
            quiet <= 1'b1;
            repeat (40) @(posedge clk_in);
            rdc("miss", `SCSR_IDX_CLK_LOOP, 32'hc0, 32'hc0);
            wr(`SCSR_IDX_CLK_CMD, 32'h60);
            rdc("miss_hold", `SCSR_IDX_CLK_LOOP, 32'h80, 32'h80);
            quiet <= 1'b0;
            repeat (8) @(posedge clk_in);
            wr(`SCSR_IDX_CLK_CMD, (i == 0) ? 32'h40 : 32'h20);
            rdc("miss_clr", `SCSR_IDX_CLK_LOOP, 32'hc0, 32'h0);
        end
        wr(`SCSR_IDX_MODE, 32'h01);
        wr(`SCSR_IDX_LOOP_CTRL, 32'h12);
        pulse(3);
        repeat (2) @(posedge clk_in);
        rdc("on_loop", `SCSR_IDX_CLK_LOOP, 32'h12, 32'h02);
        repeat (8) begin
            @(posedge clk_in);
            chk("txd_loop", 32'(txd), 32'(rxd_h[3]));
        end
        tx_act <= 1'b1;
        repeat (2) @(posedge clk_in);
        rdc("send_loop", `SCSR_IDX_CLK_LOOP, 32'h12, 32'h12);
        wr(`SCSR_IDX_LOOP_CTRL, 32'h0);
        rdc("loop_off", `SCSR_IDX_CLK_LOOP, 32'h12, 32'h0);
        repeat (4) begin
            @(posedge clk_in);
            chk("txd_pass", 32'(txd), 32'(tx_prev));
        end
        wr(`SCSR_IDX_MODE, 32'h12);
        pulse(4);
        repeat (2) @(posedge clk_in);
        rdc("tx_sync", `SCSR_IDX_CLK_LOOP, 32'h02, 32'h02);
        results();
    end
endmodule
